// ### rtl/pcc_div.sv
/*
 * One programmable post-divider producing a one-cycle pulse per divided clock edge.
 * Assumes tick and restart come from logic on the same clock.
 */
`timescale 1ns/1ns
module pcc_div #(
   parameter int RW = 5
) (
   // Clock, reset and freeze.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Source edge, realignment and ratio (divide by ratio plus one).
   input wire logic tick,
   input wire logic restart,
   input wire logic [RW-1:0] ratio,
   // Divided edge.
   output logic pulse_q
);
   logic [RW-1:0] cnt_q;
   logic [RW-1:0] cnt_d;
   logic wrap;

   if (RW < 1) begin : g_chk
      $error("pcc_div needs a ratio at least one bit wide.");
   end

   // A restart puts an edge out at once so that realigned dividers share it.
   // Wrapping at or above the ratio keeps an unaligned divider from running
   // through the whole counter range when its ratio shrinks under the count.
   assign wrap = tick & (cnt_q >= ratio);
   assign cnt_d = restart ? '0 : (wrap ? '0 : (tick ? cnt_q + 1'b1 : cnt_q));

   // Counter and edge flop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         pulse_q <= restart | wrap;
      end
   end
endmodule : pcc_div

// ### rtl/pcc_pkg.sv
/*
 * Shared types of the loop clock controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pcc_pkg;
   typedef logic [4:0] pcc_ratio_t;
   typedef logic [31:0] pcc_word_t;
endpackage : pcc_pkg

// ### rtl/pcc_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures of the loop clock controller.
 * Assumes byte addresses on the low twelve bits of the bus address.
 */
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
// Register byte offsets.
`define PCC_A_CSR 12'h0100
`define PCC_A_MULT 12'h0110
`define PCC_A_PRE 12'h0114
`define PCC_A_DIV1 12'h0118
`define PCC_A_DIV2 12'h011C
`define PCC_A_DIV3 12'h0120
`define PCC_A_CMD 12'h0138
`define PCC_A_STAT 12'h013C
`define PCC_A_ALN 12'h0140
// Field positions.
`define PCC_B_EN 0
`define PCC_B_RST 3
`define PCC_B_LOCK 6
`define PCC_B_GO 0
// Reset values and limits.
`define PCC_MULT_RST 5'h0D
`define PCC_MULT_MIN 5'h04
`define PCC_MULT_MAX 5'h19
`define PCC_DIV1_RST 5'h00
`define PCC_DIV2_RST 5'h01
`define PCC_DIV3_RST 5'h02
`define PCC_PRE_RST 5'h00
`define PCC_ALN_RST 3'h0
`define PCC_ALN_ALL 3'h7
// Timing.
`define PCC_CLK_NS 50
`define PCC_LOCK_NS 187500
`define PCC_LOCK_CYC ((`PCC_LOCK_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`endif

// ### rtl/pcc_top.sv
/*
 * Loop clock controller: APB registers, reference combination, lock timer and three
 * phase-alignable post-dividers whose outputs are edge pulses on pclk.
 * Assumes pclk stands in for the loop output while the loop is enabled, and that the
 * reference pins are asynchronous to pclk.
 */
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
`include "pcc_regs.svh"

// Notes on behaviour
// R1: Loop disabled after reset; system clocks bypassed.
// R2: Software programs ranges before enabling loop.
// R3: Software holds loop reset at least 125 ns.
// R4: Software waits lock time before enabling loop.
// R5: Pre-divided reference kept within 12-50 MHz.
// R6: Multiplier resets to 13; only 4..25 accepted.
// R7: Loop output kept within 140-600 MHz.
// R8: Post-dividers reset to divide by 1, 2, 3.
// R9: Second clock is half, third or quarter.
// R10: Software sets all three alignment bits.
// R11: Post-divider values apply only on go command.
// R12: Software resets peripheral bridge after divider changes.
// R13: Several output clocks, each own divider.
// R14: Reference is oscillator OR external pin.
// R15: Alignment and command registers are bus-mapped.
// R16: Go loads dividers together on shared edge.
module pcc_top (
   // Clock, reset and freeze.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reference pins.
   input wire logic oscillator_input_pin,
   input wire logic external_clock_pin,
   // Divided system clock edges and lock state.
   output logic system_clock_first,
   output logic system_clock_second,
   output logic system_clock_third,
   output logic loop_locked
);
   localparam int LOCK_CYC = `PCC_LOCK_CYC;

   logic osc_s1_q, osc_s2_q, ext_s1_q, ext_s2_q;
   logic ref_q, ref_prev_q;
   logic loop_enable_bit_q, loop_reset_bit_q;
   pcc_pkg::pcc_ratio_t multiplier_field_q, pre_divider_q;
   pcc_pkg::pcc_ratio_t pend_q [3];
   pcc_pkg::pcc_ratio_t act_q [3];
   logic [2:0] alignment_control_q;
   logic go_pend_q;
   logic [11:0] lock_cnt_q;
   logic [2:0] pulse;
   logic csr_touched_q, go_seen_q;
   pcc_pkg::pcc_word_t rdata;
   logic setup, access, hit, wr;
   logic wr_csr, wr_mult, wr_pre, wr_cmd, wr_aln;
   logic [2:0] wr_div;
   logic mult_ok, src_tick, ref_rise, load, relock, locked;

   // Bus phase decode; every register answers one cycle after setup.
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign hit = (paddr == `PCC_A_CSR) | (paddr == `PCC_A_MULT) | (paddr == `PCC_A_PRE)
              | (paddr == `PCC_A_DIV1) | (paddr == `PCC_A_DIV2) | (paddr == `PCC_A_DIV3)
              | (paddr == `PCC_A_CMD) | (paddr == `PCC_A_STAT) | (paddr == `PCC_A_ALN);
   assign wr = access & pwrite & hit;
   assign wr_csr = wr & (paddr == `PCC_A_CSR);
   assign wr_mult = wr & (paddr == `PCC_A_MULT);
   assign wr_pre = wr & (paddr == `PCC_A_PRE);
   assign wr_div[0] = wr & (paddr == `PCC_A_DIV1);
   assign wr_div[1] = wr & (paddr == `PCC_A_DIV2);
   assign wr_div[2] = wr & (paddr == `PCC_A_DIV3);
   assign wr_cmd = wr & (paddr == `PCC_A_CMD) & pwdata[`PCC_B_GO]; // R15
   assign wr_aln = wr & (paddr == `PCC_A_ALN); // R15

   // Out-of-range factors are dropped so the loop never sees an illegal multiplier.
   assign mult_ok = (pwdata[4:0] >= `PCC_MULT_MIN) && (pwdata[4:0] <= `PCC_MULT_MAX); // R6

   // Read mux; unused bits read as zero.
   always_comb begin
      rdata = '0;
      unique case (paddr)
         `PCC_A_CSR: begin
            rdata[`PCC_B_EN] = loop_enable_bit_q;
            rdata[`PCC_B_RST] = loop_reset_bit_q;
            rdata[`PCC_B_LOCK] = locked;
         end
         `PCC_A_MULT: rdata[4:0] = multiplier_field_q;
         `PCC_A_PRE: rdata[4:0] = pre_divider_q;
         `PCC_A_DIV1: rdata[4:0] = pend_q[0];
         `PCC_A_DIV2: rdata[4:0] = pend_q[1];
         `PCC_A_DIV3: rdata[4:0] = pend_q[2];
         `PCC_A_STAT: rdata[`PCC_B_GO] = go_pend_q;
         `PCC_A_ALN: rdata[2:0] = alignment_control_q;
         default: rdata = '0;
      endcase
   end

   // APB answer flops; an unmapped address answers with an error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (ce) begin
         pready <= setup ? 1'b1 : (access ? 1'b0 : pready);
         pslverr <= setup ? ~hit : (access ? 1'b0 : pslverr);
         if (setup && !pwrite) begin
            prdata <= rdata;
         end
      end
   end

   // Pin synchronisers; the combined reference only looks at the second stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ref_q <= 1'b0;
         ref_prev_q <= 1'b0;
      end else if (ce) begin
         osc_s1_q <= oscillator_input_pin;
         osc_s2_q <= osc_s1_q;
         ext_s1_q <= external_clock_pin;
         ext_s2_q <= ext_s1_q;
         ref_q <= osc_s2_q | ext_s2_q; // R14
         ref_prev_q <= ref_q;
      end
   end

   // Bypass counts reference edges; a running, released loop ticks every cycle.
   assign ref_rise = ref_q & ~ref_prev_q;
   assign src_tick = (loop_enable_bit_q & ~loop_reset_bit_q) | ref_rise; // R1
   assign load = ce & go_pend_q & src_tick; // R11 R16

   // Control registers; the loop starts disabled and held in reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_enable_bit_q <= 1'b0; // R1
         loop_reset_bit_q <= 1'b1;
         multiplier_field_q <= `PCC_MULT_RST; // R6
         pre_divider_q <= `PCC_PRE_RST;
         alignment_control_q <= `PCC_ALN_RST;
         csr_touched_q <= 1'b0;
      end else if (ce) begin
         if (wr_csr) begin
            loop_enable_bit_q <= pwdata[`PCC_B_EN];
            loop_reset_bit_q <= pwdata[`PCC_B_RST];
            csr_touched_q <= 1'b1;
         end
         if (wr_mult && mult_ok) begin
            multiplier_field_q <= pwdata[4:0]; // R6
         end
         if (wr_pre) begin
            pre_divider_q <= pwdata[4:0];
         end
         if (wr_aln) begin
            alignment_control_q <= pwdata[2:0];
         end
      end
   end

   // Lock timer restarts on any change to the loop inputs or while reset is held.
   assign relock = wr_mult | wr_pre | loop_reset_bit_q;
   assign locked = (lock_cnt_q == 12'(LOCK_CYC));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_q <= '0;
         loop_locked <= 1'b0;
      end else if (ce) begin
         lock_cnt_q <= relock ? '0 : (locked ? lock_cnt_q : lock_cnt_q + 12'h0001);
         loop_locked <= locked & ~relock;
      end
   end

   // Go command: a new request wins over the load that clears the old one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_pend_q <= 1'b0;
         go_seen_q <= 1'b0;
      end else if (ce) begin
         go_pend_q <= wr_cmd | (go_pend_q & ~src_tick); // R11
         go_seen_q <= go_seen_q | load;
      end
   end

   // Pending and active divider ratios; writes only stage, a go load applies all three.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q[0] <= `PCC_DIV1_RST; // R8
         pend_q[1] <= `PCC_DIV2_RST;
         pend_q[2] <= `PCC_DIV3_RST;
         act_q[0] <= `PCC_DIV1_RST;
         act_q[1] <= `PCC_DIV2_RST;
         act_q[2] <= `PCC_DIV3_RST;
      end else if (ce) begin
         for (int i = 0; i < 3; i++) begin
            if (wr_div[i]) begin
               pend_q[i] <= pwdata[4:0];
            end
            if (load) begin
               act_q[i] <= pend_q[i]; // R11
            end
         end
      end
   end

   // Three dividers; aligned ones restart together so they share an edge.
   for (genvar g = 0; g < 3; g++) begin : g_div
      pcc_div #(.RW(5)) u_div ( // R13
         .clk(pclk),
         .rst_n(presetn),
         .ce(ce),
         .tick(src_tick),
         .restart(load & alignment_control_q[g]), // R16
         .ratio(act_q[g]),
         .pulse_q(pulse[g])
      );
   end
   assign system_clock_first = pulse[0];
   assign system_clock_second = pulse[1];
   assign system_clock_third = pulse[2];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_bypass;
      !csr_touched_q |-> !loop_enable_bit_q;
   endproperty
   a_bypass: assert property (p_bypass) else $error("Loop enabled without a write."); // R1

   property p_mult_range;
      (multiplier_field_q >= `PCC_MULT_MIN) && (multiplier_field_q <= `PCC_MULT_MAX);
   endproperty
   a_mult_range: assert property (p_mult_range) else $error("Multiplier out of range."); // R6

   property p_mult_reject;
      ce && wr_mult && !mult_ok |=> $stable(multiplier_field_q);
   endproperty
   a_mult_reject: assert property (p_mult_reject) else $error("Bad factor accepted."); // R6

   property p_div_default;
      !go_seen_q |-> (act_q[0] == `PCC_DIV1_RST) && (act_q[1] == `PCC_DIV2_RST)
                     && (act_q[2] == `PCC_DIV3_RST);
   endproperty
   a_div_default: assert property (p_div_default) else $error("Divider defaults wrong."); // R8

   property p_go_only;
      !$stable(act_q[1]) |-> $past(load);
   endproperty
   a_go_only: assert property (p_go_only) else $error("Divider changed without go."); // R11

   property p_shared_edge;
      load && (alignment_control_q == `PCC_ALN_ALL) |=> pulse == 3'h7;
   endproperty
   a_shared_edge: assert property (p_shared_edge) else $error("Aligned edges not shared."); // R16

   property p_ref_or;
      $past(ce) |-> ref_q == $past(osc_s2_q | ext_s2_q);
   endproperty
   a_ref_or: assert property (p_ref_or) else $error("Reference not combined."); // R14

   property p_go_reg;
      ce && wr_cmd |=> go_pend_q ##0 (rdata[`PCC_B_GO] || paddr != `PCC_A_STAT);
   endproperty
   a_go_reg: assert property (p_go_reg) else $error("Go command not registered."); // R15

   property p_first_src;
      ce && !load && src_tick && act_q[0] == `PCC_DIV1_RST |=> pulse[0];
   endproperty
   a_first_src: assert property (p_first_src) else $error("First clock missed an edge."); // R13

   c_enable: cover property (wr_csr && pwdata[`PCC_B_EN]);
   c_go_load: cover property (load && alignment_control_q == `PCC_ALN_ALL);
   c_locked: cover property ($rose(loop_locked));
   c_unmapped: cover property (pready && pslverr);
endmodule : pcc_top

// ### verification/pcc_ref_src.sv
/*
 * Reference source that stands in for the crystal oscillator or the external clock pin.
 * Assumes the bench picks which pin runs; the other pin is held low all the time.
 */
`timescale 1ns/1ns
module pcc_ref_src #(
   parameter int HALF_NS = 200
) (
   // Source choice.
   input wire logic sel_ext,
   // Reference pins.
   output logic oscillator_input_pin,
   output logic external_clock_pin
);
   logic osc_q = 1'b0;
   // Free-running source; the offset keeps its edges away from pclk edges.
   initial begin
      #13;
      forever #HALF_NS osc_q = ~osc_q;
   end
   // The idle pin must sit low, since the device ORs both pins together.
   assign oscillator_input_pin = osc_q & ~sel_ext;
   assign external_clock_pin = osc_q & sel_ext;
endmodule : pcc_ref_src

// ### verification/test_pll_clock_controller.sv
/*
 * Self-checking bench for the loop clock controller, driving it over APB.
 * Assumes a reference period of eight pclk cycles from the partner source.
 */
`timescale 1ns/1ns
`include "pcc_regs.svh"
module test_pll_clock_controller;
   // Bench signals.
   logic pclk, presetn, psel, penable, pwrite, sel_ext, pready, pslverr, err, ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic osc_pin, ext_pin, clk1, clk2, clk3, locked;
   int n_fail = 0;
   int n_tests = 0;
   int c1, c2, c3, c23, i;
   logic [11:0] ra [8] = '{`PCC_A_CSR, `PCC_A_MULT, `PCC_A_PRE, `PCC_A_DIV1, `PCC_A_DIV2,
      `PCC_A_DIV3, `PCC_A_ALN, `PCC_A_STAT};
   logic [31:0] rv [8] = '{32'h0000_0008, 32'h0000_000D, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0001, 32'h0000_0002, 32'h0000_0000, 32'h0000_0000};
   logic [31:0] mw [4] = '{32'h0000_0003, 32'h0000_001A, 32'h0000_0004, 32'h0000_0019};
   logic [31:0] me [4] = '{32'h0000_000D, 32'h0000_000D, 32'h0000_0004, 32'h0000_0019};

   // Device and reference source; ce drops once to show that the lock timer freezes.
   pcc_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .oscillator_input_pin(osc_pin), .external_clock_pin(ext_pin),
      .system_clock_first(clk1), .system_clock_second(clk2), .system_clock_third(clk3),
      .loop_locked(locked));
   pcc_ref_src u_src (.sel_ext(sel_ext), .oscillator_input_pin(osc_pin),
      .external_clock_pin(ext_pin));

   // Clock of 50 ns.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Compares one value and counts the outcome.
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer; one idle cycle follows so no signal is assigned twice at one edge.
   // Only the watchdog ends a wait for pready.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rd, exp);
   endtask : rdchk

   // Counts divided edges over a window; windows are whole multiples of every period.
   task automatic count(input int n);
      c1 = 0;
      c2 = 0;
      c3 = 0;
      c23 = 0;
      repeat (n) begin
         @(posedge pclk);
         c1 += clk1;
         c2 += clk2;
         c3 += clk3;
         c23 += clk2 & clk3;
      end
   endtask : count

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // Watchdog sized well beyond three lock waits plus the bypass windows.
   initial begin
      repeat (30000) @(posedge pclk);
      n_fail++;
      $display("Error watchdog expired");
      tally_and_finish();
   end

   // Main sequence.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      sel_ext = 1'b0;
      ce = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 8; i++) rdchk(ra[i], rv[i], "reset value");
      apb(1'b0, 12'h0104, 32'h0000_0000);
      chk("unmapped error", err, 32'h0000_0001);
      // Bypass: each source alone must drive the dividers at 1, 1/2 and 1/3 of its rate.
      for (i = 0; i < 2; i++) begin
         sel_ext <= i[0];
         repeat (40) @(posedge pclk);
         count(384);
         chk("bypass first", c1, 32'h0000_0030);
         chk("bypass second", c2, 32'h0000_0018);
         chk("bypass third", c3, 32'h0000_0010);
      end
      for (i = 0; i < 4; i++) begin
         apb(1'b1, `PCC_A_MULT, mw[i]);
         rdchk(`PCC_A_MULT, me[i], "multiplier");
      end
      apb(1'b1, `PCC_A_PRE, 32'h0000_0001);
      // Loop reset has been held far longer than 125 ns by now.
      apb(1'b1, `PCC_A_CSR, 32'h0000_0000);
      repeat (`PCC_LOCK_CYC - 10) @(posedge pclk);
      chk("early lock", locked, 32'h0000_0000);
      repeat (20) @(posedge pclk);
      chk("lock", locked, 32'h0000_0001);
      rdchk(`PCC_A_CSR, 32'h0000_0040, "status lock");
      apb(1'b1, `PCC_A_MULT, 32'h0000_0014);
      repeat (2) @(posedge pclk);
      chk("relock", locked, 32'h0000_0000);
      // A frozen controller must not count lock time, or software could enable too early.
      ce <= 1'b0;
      repeat (`PCC_LOCK_CYC + 50) @(posedge pclk);
      chk("frozen lock", locked, 32'h0000_0000);
      ce <= 1'b1;
      i = 0;
      while (locked !== 1'b1 && i < 5000) begin
         @(posedge pclk);
         i++;
      end
      chk("relocked", locked, 32'h0000_0001);
      apb(1'b1, `PCC_A_CSR, 32'h0000_0001);
      rdchk(`PCC_A_CSR, 32'h0000_0041, "enabled");
      count(48);
      chk("loop first", c1, 32'h0000_0030);
      chk("loop second", c2, 32'h0000_0018);
      chk("loop third", c3, 32'h0000_0010);
      apb(1'b1, `PCC_A_ALN, 32'h0000_0007);
      rdchk(`PCC_A_ALN, 32'h0000_0007, "align");
      apb(1'b1, `PCC_A_DIV2, 32'h0000_0003);
      apb(1'b1, `PCC_A_DIV3, 32'h0000_0001);
      rdchk(`PCC_A_DIV2, 32'h0000_0003, "staged ratio");
      count(48);
      chk("staged second", c2, 32'h0000_0018);
      chk("staged third", c3, 32'h0000_0010);
      // The peripheral bridge lives outside this block, so only the go write is due.
      apb(1'b1, `PCC_A_CMD, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      rdchk(`PCC_A_STAT, 32'h0000_0000, "go consumed");
      count(48);
      chk("new first", c1, 32'h0000_0030);
      chk("new second", c2, 32'h0000_000C);
      chk("new third", c3, 32'h0000_0018);
      chk("shared edges", c23, 32'h0000_000C);
      // A second reset mid-run must bring back bypass and the default ratios.
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(`PCC_A_CSR, 32'h0000_0008, "reset again csr");
      rdchk(`PCC_A_DIV2, 32'h0000_0001, "reset again ratio");
      count(384);
      chk("reset again second", c2, 32'h0000_0018);
      tally_and_finish();
   end
endmodule : test_pll_clock_controller
